// ---- inc/timer_pair_pkg.sv ----
// register map, field positions and constants of the dual timer/counter
package timer_pair_pkg;

  // ********************************************************************
  // register offsets (byte addresses on the plain register port)
  // ********************************************************************
  localparam logic [7:0] addr_control     = 8'h88;
  localparam logic [7:0] addr_mode_config = 8'h89;
  localparam logic [7:0] addr_zero_low    = 8'h8a;
  localparam logic [7:0] addr_one_low     = 8'h8b;
  localparam logic [7:0] addr_zero_high   = 8'h8c;
  localparam logic [7:0] addr_one_high    = 8'h8d;
  localparam logic [7:0] addr_irq_status  = 8'h8e;
  localparam logic [7:0] addr_irq_mask    = 8'h8f;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] mode_config_reset = 8'h00;
  localparam logic [7:0] control_reset     = 8'h00;
  localparam logic [7:0] count_reset       = 8'h00;
  localparam logic [1:0] irq_reset         = 2'h0;

  // ********************************************************************
  // mode config field positions (timer one in high nibble)
  // ********************************************************************
  localparam int one_gate_bit   = 7;
  localparam int one_source_bit = 6;
  localparam int one_mode_hi    = 5;
  localparam int one_mode_lo    = 4;
  localparam int zero_gate_bit  = 3;
  localparam int zero_source_bit = 2;
  localparam int zero_mode_hi   = 1;
  localparam int zero_mode_lo   = 0;

  // control register field positions
  localparam int one_flag_bit  = 7;
  localparam int one_run_bit   = 6;
  localparam int zero_flag_bit = 5;
  localparam int zero_run_bit  = 4;

  // interrupt status / mask bit positions
  localparam int irq_zero_bit = 0;
  localparam int irq_one_bit  = 1;

  // ********************************************************************
  // timer mode field encodings
  // ********************************************************************
  localparam logic [1:0] mode_prescale = 2'h0;
  localparam logic [1:0] mode_cascade  = 2'h1;
  localparam logic [1:0] mode_reload   = 2'h2;
  localparam logic [1:0] mode_split    = 2'h3;

  localparam logic [4:0] prescale_top = 5'h1f;
  localparam logic [7:0] byte_top     = 8'hff;

endpackage

// ---- hdl/dual_timer_counter.sv ----
// dual 16-bit timer/counter with mode register and register port
`timescale 1ns/100ps

module dual_timer_counter (
  input  wire logic       sys_clk,           // core clock, 40 MHz
  input  wire logic       reset_n,           // async reset, active low
  input  wire logic [7:0] reg_addr,          // register address
  input  wire logic [7:0] reg_wdata,         // register write data
  input  wire logic       reg_wr,            // write strobe
  input  wire logic       reg_rd,            // read strobe
  output logic      [7:0] reg_rdata,         // read data, cycle after rd
  input  wire logic       event_input_zero,  // timer zero count pin
  input  wire logic       event_input_one,   // timer one count pin
  input  wire logic       ext_irq_zero_pin,  // timer zero gate pin
  input  wire logic       ext_irq_one_pin,   // timer one gate pin
  input  wire logic       vector_zero_ack,   // core vectors to zero isr
  input  wire logic       vector_one_ack,    // core vectors to one isr
  output logic            irq                // level interrupt
);

  // ********************************************************************
  // reset release and pin synchronisers
  // ********************************************************************
  logic       rst_meta;
  logic       rst_sync_n;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] pin_prev;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pins feed only the first flop; edge logic reads pin_sync onward
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {ext_irq_one_pin, ext_irq_zero_pin,
                   event_input_one, event_input_zero};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[1:0];
    end
  end

  // ********************************************************************
  // count enables
  // ********************************************************************
  logic [7:0] mode_config;
  logic [7:0] control;
  logic [7:0] zero_low;
  logic [7:0] zero_high;
  logic [7:0] one_low;
  logic [7:0] one_high;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  logic [1:0] fall;
  logic       zero_run_ok;
  logic       one_run_ok;
  logic       zero_tick;
  logic       one_tick;
  logic       split_tick;
  logic [1:0] zero_mode;
  logic [1:0] one_mode;

  always_comb begin
    // one sample high, next low; edge seen two periods after change
    fall = pin_prev & ~pin_sync[1:0];
    zero_mode = mode_config[timer_pair_pkg::zero_mode_hi:
                            timer_pair_pkg::zero_mode_lo];
    one_mode  = mode_config[timer_pair_pkg::one_mode_hi:
                            timer_pair_pkg::one_mode_lo];
    zero_run_ok = control[timer_pair_pkg::zero_run_bit] &
                  (~mode_config[timer_pair_pkg::zero_gate_bit] |
                   pin_sync[2]);
    one_run_ok  = control[timer_pair_pkg::one_run_bit] &
                  (~mode_config[timer_pair_pkg::one_gate_bit] |
                   pin_sync[3]);
    zero_tick = zero_run_ok &
                (mode_config[timer_pair_pkg::zero_source_bit] ?
                 fall[0] : 1'b1);
    one_tick  = one_run_ok &
                (mode_config[timer_pair_pkg::one_source_bit] ?
                 fall[1] : 1'b1);
    // split high byte: timer only, under timer one run bit
    split_tick = control[timer_pair_pkg::one_run_bit];
  end

  // ********************************************************************
  // counters
  // ********************************************************************
  logic [7:0] next_zero_low;
  logic [7:0] next_zero_high;
  logic [7:0] next_one_low;
  logic [7:0] next_one_high;
  logic       zero_ovf;
  logic       one_ovf;

  always_comb begin
    next_zero_low  = zero_low;
    next_zero_high = zero_high;
    next_one_low   = one_low;
    next_one_high  = one_high;
    zero_ovf = 1'b0;
    one_ovf  = 1'b0;

    // timer zero
    unique case (zero_mode)
      timer_pair_pkg::mode_prescale: begin
        if (zero_tick) begin
          next_zero_low = {3'h0, zero_low[4:0] + 5'h01};
          if (zero_low[4:0] == timer_pair_pkg::prescale_top) begin
            next_zero_high = zero_high + 8'h01;
            zero_ovf = (zero_high == timer_pair_pkg::byte_top);
          end
        end
      end
      timer_pair_pkg::mode_cascade: begin
        if (zero_tick) begin
          {next_zero_high, next_zero_low} =
            16'({zero_high, zero_low} + 16'h0001);
          zero_ovf = ({zero_high, zero_low} == 16'hffff);
        end
      end
      timer_pair_pkg::mode_reload: begin
        if (zero_tick) begin
          if (zero_low == timer_pair_pkg::byte_top) begin
            next_zero_low = zero_high;
            zero_ovf = 1'b1;
          end else begin
            next_zero_low = zero_low + 8'h01;
          end
        end
      end
      timer_pair_pkg::mode_split: begin
        if (zero_tick) begin
          next_zero_low = zero_low + 8'h01;
          zero_ovf = (zero_low == timer_pair_pkg::byte_top);
        end
        if (split_tick) begin
          next_zero_high = zero_high + 8'h01;
          one_ovf = (zero_high == timer_pair_pkg::byte_top);
        end
      end
    endcase

    // timer one; in split mode of zero it keeps counting but
    // its overflow flag is owned by the split high byte
    unique case (one_mode)
      timer_pair_pkg::mode_prescale: begin
        if (one_tick) begin
          next_one_low = {3'h0, one_low[4:0] + 5'h01};
          if (one_low[4:0] == timer_pair_pkg::prescale_top) begin
            next_one_high = one_high + 8'h01;
            if (zero_mode != timer_pair_pkg::mode_split)
              one_ovf = (one_high == timer_pair_pkg::byte_top);
          end
        end
      end
      timer_pair_pkg::mode_cascade: begin
        if (one_tick) begin
          {next_one_high, next_one_low} =
            16'({one_high, one_low} + 16'h0001);
          if (zero_mode != timer_pair_pkg::mode_split)
            one_ovf = ({one_high, one_low} == 16'hffff);
        end
      end
      timer_pair_pkg::mode_reload: begin
        if (one_tick) begin
          if (one_low == timer_pair_pkg::byte_top) begin
            next_one_low = one_high;
            if (zero_mode != timer_pair_pkg::mode_split)
              one_ovf = 1'b1;
          end else begin
            next_one_low = one_low + 8'h01;
          end
        end
      end
      timer_pair_pkg::mode_split: begin
        // halted: counts hold their value
      end
    endcase

    // software writes override counting in the same cycle
    if (reg_wr) begin
      unique case (reg_addr)
        timer_pair_pkg::addr_zero_low:  next_zero_low  = reg_wdata;
        timer_pair_pkg::addr_zero_high: next_zero_high = reg_wdata;
        timer_pair_pkg::addr_one_low:   next_one_low   = reg_wdata;
        timer_pair_pkg::addr_one_high:  next_one_high  = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      zero_low  <= timer_pair_pkg::count_reset;
      zero_high <= timer_pair_pkg::count_reset;
      one_low   <= timer_pair_pkg::count_reset;
      one_high  <= timer_pair_pkg::count_reset;
    end else begin
      zero_low  <= next_zero_low;
      zero_high <= next_zero_high;
      one_low   <= next_one_low;
      one_high  <= next_one_high;
    end
  end

  // ********************************************************************
  // control, mode, interrupt registers
  // ********************************************************************
  logic [7:0] next_mode_config;
  logic [7:0] next_control;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [7:0] next_reg_rdata;
  logic       next_irq;

  always_comb begin
    next_mode_config = mode_config;
    next_control     = control;
    next_irq_status  = irq_status;
    next_irq_mask    = irq_mask;
    next_reg_rdata   = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        timer_pair_pkg::addr_mode_config: next_mode_config = reg_wdata;
        timer_pair_pkg::addr_control:     next_control     = reg_wdata;
        timer_pair_pkg::addr_irq_status:
          next_irq_status = irq_status & ~reg_wdata[1:0];
        timer_pair_pkg::addr_irq_mask:    next_irq_mask = reg_wdata[1:0];
        default: ;
      endcase
    end
    // vector acknowledge clears; a new overflow in the same cycle wins
    if (vector_zero_ack)
      next_control[timer_pair_pkg::zero_flag_bit] = 1'b0;
    if (vector_one_ack)
      next_control[timer_pair_pkg::one_flag_bit] = 1'b0;
    if (zero_ovf) begin
      next_control[timer_pair_pkg::zero_flag_bit] = 1'b1;
      next_irq_status[timer_pair_pkg::irq_zero_bit] = 1'b1;
    end
    if (one_ovf) begin
      next_control[timer_pair_pkg::one_flag_bit] = 1'b1;
      next_irq_status[timer_pair_pkg::irq_one_bit] = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        timer_pair_pkg::addr_control:     next_reg_rdata = control;
        timer_pair_pkg::addr_mode_config: next_reg_rdata = mode_config;
        timer_pair_pkg::addr_zero_low:    next_reg_rdata = zero_low;
        timer_pair_pkg::addr_zero_high:   next_reg_rdata = zero_high;
        timer_pair_pkg::addr_one_low:     next_reg_rdata = one_low;
        timer_pair_pkg::addr_one_high:    next_reg_rdata = one_high;
        timer_pair_pkg::addr_irq_status:
          next_reg_rdata = {6'h00, irq_status};
        timer_pair_pkg::addr_irq_mask:    next_reg_rdata = {6'h00, irq_mask};
        default: next_reg_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_config <= timer_pair_pkg::mode_config_reset;
      control     <= timer_pair_pkg::control_reset;
      irq_status  <= timer_pair_pkg::irq_reset;
      irq_mask    <= timer_pair_pkg::irq_reset;
      reg_rdata   <= 8'h00;
      irq         <= 1'b0;
    end else begin
      mode_config <= next_mode_config;
      control     <= next_control;
      irq_status  <= next_irq_status;
      irq_mask    <= next_irq_mask;
      reg_rdata   <= next_reg_rdata;
      irq         <= next_irq;
    end
  end

endmodule // dual_timer_counter

// ---- verif/dual_timer_counter_properties.sv ----
// port-level assertions for the dual timer/counter
`timescale 1ns/100ps
module dual_timer_counter_properties (
  input wire logic       sys_clk,   // core clock
  input wire logic       reset_n,   // async reset, active low
  input wire logic [7:0] reg_addr,  // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic       reg_wr,    // write strobe
  input wire logic       reg_rd,    // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic       irq        // level interrupt
);
  localparam logic [7:0] am = timer_pair_pkg::addr_mode_config;
  localparam logic [7:0] ac = timer_pair_pkg::addr_control;
  localparam logic [7:0] ak = timer_pair_pkg::addr_irq_mask;
  wire rz = reg_rd && reg_addr == timer_pair_pkg::addr_zero_low;
  wire r1 = reg_rd && reg_addr == timer_pair_pkg::addr_one_low;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ******************************************************************
  // register port
  // ******************************************************************
  AST_RDATA_IDLE: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (
      reg_rd && (reg_addr < 8'h88 || reg_addr > 8'h8f)
      |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MODE_BACK: assert property (
      reg_wr && reg_addr == am ##1 reg_rd && reg_addr == am
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mode readback differs");
  AST_RUN_BACK: assert property (
      reg_wr && reg_addr == ac ##1 reg_rd && reg_addr == ac
      |=> (reg_rdata & 8'h5f) == ($past(reg_wdata, 2) & 8'h5f))
    else $error("run bits readback differs");

  // ******************************************************************
  // counting and interrupt
  // ******************************************************************
  AST_MASK_OFF: assert property (
      reg_wr && reg_addr == ak && reg_wdata == 8'h00
      ##1 !(reg_wr && reg_addr == ak) |=> !irq)
    else $error("irq high with mask clear");
  AST_ONE_HALT: assert property (
      reg_wr && reg_addr == am && reg_wdata[5:4] == 2'h3 ##1 r1 ##1 r1
      |=> reg_rdata == $past(reg_rdata))
    else $error("halted timer one moved");
  AST_ZERO_STEP: assert property (
      reg_wr && reg_addr == am && reg_wdata[3:0] == 4'h1
      ##1 reg_wr && reg_addr == ac && reg_wdata[4] ##1 rz ##1 rz
      |=> reg_rdata == $past(reg_rdata) + 8'h01)
    else $error("timer zero not one per cycle");
  AST_STOP_HOLD: assert property (
      reg_wr && reg_addr == ac && !reg_wdata[4] ##1 rz ##1 rz
      |=> reg_rdata == $past(reg_rdata))
    else $error("stopped timer zero moved");
endmodule // dual_timer_counter_properties

bind dual_timer_counter dual_timer_counter_properties chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));

// ---- verif/event_source.sv ----
// pin-side model: bursts of falls on count pins, levels on gate pins
`timescale 1ns/100ps
module event_source (
  input  wire logic       sys_clk,          // core clock
  input  wire logic       go,               // start a burst
  input  wire logic       sel_one,          // burst on pin one
  input  wire logic [7:0] n_falls,          // falls in the burst
  input  wire logic [1:0] gate_lvl,         // gate levels, one:zero
  output logic            event_input_zero, // count pin zero
  output logic            event_input_one,  // count pin one
  output logic            ext_irq_zero_pin, // gate pin zero
  output logic            ext_irq_one_pin,  // gate pin one
  output logic            busy              // burst running
);
  logic [9:0] cnt = 10'h000;
  logic       sel = 1'b0;
  // count pins idle high as on a pulled-up port; each level lasts two cycles,
  // above the one-cycle minimum, so the device never misses one
  wire lvl = (cnt == 10'h000) | ~cnt[1];
  always @(posedge sys_clk) begin
    if (go) begin
      cnt <= {n_falls, 2'b00};
      sel <= sel_one;
    end else if (cnt != 10'h000) begin
      cnt <= cnt - 10'h001;
    end
  end
  assign event_input_zero = sel | lvl;
  assign event_input_one  = ~sel | lvl;
  assign ext_irq_zero_pin = gate_lvl[0];
  assign ext_irq_one_pin  = gate_lvl[1];
  assign busy             = cnt != 10'h000;
endmodule // event_source

// ---- verif/tb_dual_timer_counter.sv ----
// self-checking bench for the dual timer/counter
`timescale 1ns/100ps
module tb_dual_timer_counter;
  localparam logic [7:0] am  = timer_pair_pkg::addr_mode_config;
  localparam logic [7:0] ac  = timer_pair_pkg::addr_control;
  localparam logic [7:0] azl = timer_pair_pkg::addr_zero_low;
  localparam logic [7:0] azh = timer_pair_pkg::addr_zero_high;
  localparam logic [7:0] a1l = timer_pair_pkg::addr_one_low;
  localparam logic [7:0] a1h = timer_pair_pkg::addr_one_high;
  localparam logic [7:0] ak  = timer_pair_pkg::addr_irq_mask;
  localparam logic [7:0] as  = timer_pair_pkg::addr_irq_status;
  logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       ack0 = 1'b0, go = 1'b0, irq, busy, ev0, ev1, gp0, gp1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       ack1 = 1'b0, sel1 = 1'b0;
  logic [1:0] gate_lvl = 2'h0;
  int         bad_count = 0, n_compared = 0, cycles = 0, k;

  dual_timer_counter dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input_zero(ev0),
    .event_input_one(ev1), .ext_irq_zero_pin(gp0), .ext_irq_one_pin(gp1),
    .vector_zero_ack(ack0), .vector_one_ack(ack1), .irq(irq));
  event_source src (.sys_clk(sys_clk), .go(go), .sel_one(sel1),
    .n_falls(8'h06), .gate_lvl(gate_lvl), .event_input_zero(ev0),
    .event_input_one(ev1), .ext_irq_zero_pin(gp0), .ext_irq_one_pin(gp1),
    .busy(busy));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end

  // ******************************************************************
  // access tasks: each waits an edge first, so strobes chain with no gap
  // ******************************************************************
  task automatic acc(input logic w, r, input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic r2(input logic [7:0] a);
    repeat (2) acc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic cmp(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk(input logic [7:0] a, e);
    acc(1'b0, 1'b1, a, 8'h00);
    idle(1);
    @(negedge sys_clk);
    cmp($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic irqchk(input logic e);
    idle(2);
    @(negedge sys_clk);
    cmp("irq", {7'h00, irq}, {7'h00, e});
  endtask
  // busy is read one edge after go, once the model has loaded its count
  task automatic burst(input logic one);
    @(posedge sys_clk);
    sel1 <= one;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (busy === 1'b1 && k < 100);
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(am, 8'h00);
    chk(ac, 8'h00);
    chk(azl, 8'h00);
    chk(8'h87, 8'h00);
    wr(am, 8'ha5);
    chk(am, 8'ha5);
    wr(ac, 8'h0a);
    chk(ac, 8'h0a);
    $display("test registers done");
    wr(azl, 8'hfe);
    wr(azh, 8'h00);
    wr(am, 8'h11);
    wr(ac, 8'h10);
    r2(azl);
    idle(17);
    wr(ac, 8'h00);
    r2(azl);
    chk(azl, 8'h12);
    chk(azh, 8'h01);
    chk(ac, 8'h00);
    $display("test cascade done");
    wr(am, 8'h02);
    wr(azh, 8'hf0);
    wr(azl, 8'hfd);
    wr(ak, 8'h01);
    wr(ac, 8'h10);
    idle(4);
    chk(ac, 8'h30);
    wr(ac, 8'h20);
    chk(azl, 8'hf4);
    chk(as, 8'h01);
    irqchk(1'b1);
    @(posedge sys_clk) ack0 <= 1'b1;
    @(posedge sys_clk) ack0 <= 1'b0;
    chk(ac, 8'h00);
    wr(ak, 8'h00);
    irqchk(1'b0);
    wr(as, 8'h01);
    wr(ak, 8'h01);
    irqchk(1'b0);
    chk(as, 8'h00);
    $display("test reload and flag done");
    wr(am, 8'h05);
    wr(azl, 8'h00);
    wr(azh, 8'h00);
    wr(ac, 8'h10);
    burst(1'b0);
    idle(6);
    wr(ac, 8'h00);
    chk(azl, 8'h06);
    wr(am, 8'h09);
    wr(azl, 8'h00);
    wr(ac, 8'h10);
    idle(10);
    wr(ac, 8'h00);
    chk(azl, 8'h00);
    gate_lvl <= 2'h1;
    idle(4);
    wr(ac, 8'h10);
    idle(4);
    wr(ac, 8'h00);
    chk(azl, 8'h05);
    $display("test pins and gate done");
    wr(azl, 8'h00);
    wr(azh, 8'h00);
    wr(am, 8'h33);
    r2(a1l);
    wr(ac, 8'h40);
    idle(5);
    wr(ac, 8'h00);
    chk(azh, 8'h06);
    chk(azl, 8'h00);
    chk(a1l, 8'h00);
    $display("test split and halt done");
    wr(am, 8'h00);
    wr(azl, 8'hfe);
    wr(azh, 8'hff);
    wr(ac, 8'h10);
    idle(1);
    wr(ac, 8'h00);
    chk(azl, 8'h00);
    chk(azh, 8'h00);
    chk(ac, 8'h20);
    wr(am, 8'h20);
    wr(a1h, 8'h80);
    wr(a1l, 8'hfe);
    wr(ac, 8'h40);
    idle(2);
    chk(ac, 8'hc0);
    wr(ac, 8'h80);
    chk(a1l, 8'h83);
    chk(as, 8'h03);
    @(posedge sys_clk) ack1 <= 1'b1;
    @(posedge sys_clk) ack1 <= 1'b0;
    chk(ac, 8'h00);
    wr(am, 8'h10);
    wr(a1l, 8'hff);
    wr(a1h, 8'h00);
    wr(ac, 8'h40);
    idle(1);
    wr(ac, 8'h00);
    chk(a1h, 8'h01);
    chk(a1l, 8'h01);
    $display("test prescale and timer one done");
    wr(am, 8'h50);
    wr(a1l, 8'h00);
    wr(a1h, 8'h00);
    wr(ac, 8'h40);
    burst(1'b1);
    idle(6);
    wr(ac, 8'h00);
    chk(a1l, 8'h06);
    wr(am, 8'h90);
    wr(a1l, 8'h00);
    wr(ac, 8'h40);
    idle(3);
    wr(ac, 8'h00);
    chk(a1l, 8'h00);
    gate_lvl <= 2'h3;
    idle(4);
    wr(ac, 8'h40);
    idle(2);
    wr(ac, 8'h00);
    chk(a1l, 8'h03);
    $display("test timer one pins done");
    results();
  end
endmodule // tb_dual_timer_counter
